// >>> core/fbhp_host.sv
/*
 Host end of the flash buffer host port: AXI4-Lite register slave that
 runs single reads, single writes and burst reads on the link.
 Assumes the link inputs are asynchronous; it makes the burst clock
 itself by dividing CORE_CLK.
*/
`timescale 1ns/100ps
module fbhp_host
	import fbhp_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SRST,
	fbhp_link_if.host LINK,
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	logic [AXI_AW-1:0] aw_q;
	logic [AXI_AW-1:0] ar;
	logic [31:0] w_q;
	logic [31:0] rd_mux;
	logic [3:0] ws_q;
	logic aw_full_q;
	logic w_full_q;
	logic do_wr;
	logic wr_ok;
	logic go;
	logic [17:0] s1_q;
	logic [17:0] s2_q;
	logic [DW-1:0] dq_s;
	logic [DW-1:0] addr_q;
	logic [DW-1:0] wdata_q;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] cap_q [CAP_WORDS];
	logic [1:0] op_q;
	logic [CAP_W-1:0] len_q;
	logic [CAP_W-1:0] wcnt_q;
	logic hwrst_q;
	fbhp_host_t st_q;
	fbhp_host_t st_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic [TMR_W-1:0] div_q;
	logic lclk_q;
	logic lclk_rise;
	logic avd_done_q;
	logic take;
	logic idle;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign S_AXI_AWREADY = ~aw_full_q;
	assign S_AXI_WREADY = ~w_full_q;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign do_wr = aw_full_q & w_full_q & ~S_AXI_BVALID;
	assign idle = (st_q == H_IDLE);
	assign wr_ok = (aw_q == AX_CTRL) | (aw_q == AX_ADDR)
		| (aw_q == AX_WDATA) | (aw_q == AX_HWRST);
	assign go = do_wr & idle & (aw_q == AX_CTRL) & ws_q[0];
	assign ar = S_AXI_ARADDR;
	assign rd_mux = ar[AX_CAP_BIT] ? {16'h0000, cap_q[ar[CAP_W+1:2]]} :
		(ar == AX_CTRL) ? {23'h0, len_q, 2'h0, op_q} :
		(ar == AX_ADDR) ? {16'h0000, addr_q} :
		(ar == AX_WDATA) ? {16'h0000, wdata_q} :
		(ar == AX_STAT) ? {30'h0, s2_q[17], ~idle} :
		(ar == AX_RDATA) ? {16'h0000, rdata_q} :
		(ar == AX_HWRST) ? {31'h0, hwrst_q} : 32'h0000_0000;

	// Address and data taken in either order; response after both
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_q <= '0;
			w_q <= '0;
			ws_q <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && !aw_full_q)
			begin
				aw_full_q <= 1'b1;
				aw_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_full_q)
			begin
				w_full_q <= 1'b1;
				w_q <= S_AXI_WDATA;
				ws_q <= S_AXI_WSTRB;
			end
			if (do_wr)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Read answer one cycle after address
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && !S_AXI_RVALID)
		begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_mux;
			S_AXI_RRESP <= (ar[AX_CAP_BIT] || ar <= AX_HWRST) && ar[1:0] == 2'h0
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end

	// Operation setup words; byte lanes 0 and 1 hold them
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			op_q <= OP_READ;
			len_q <= '0;
			addr_q <= '0;
			wdata_q <= '0;
			hwrst_q <= 1'b1;
		end
		else if (do_wr && idle)
		begin
			if (go)
				op_q <= w_q[1:0];
			if (aw_q == AX_CTRL && ws_q[0])
				len_q <= w_q[CTRL_LEN_LSB +: CAP_W];
			if (aw_q == AX_ADDR && ws_q[1:0] == 2'h3)
				addr_q <= w_q[DW-1:0];
			if (aw_q == AX_WDATA && ws_q[1:0] == 2'h3)
				wdata_q <= w_q[DW-1:0];
			if (aw_q == AX_HWRST && ws_q[0])
				hwrst_q <= w_q[0];
		end
	end

	// ------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------
	// Two-stage sync of device data, ready and interrupt wire
	always_ff @(posedge CORE_CLK)
	begin
		s1_q <= {LINK.int_line, LINK.rdy, LINK.dq};
		s2_q <= s1_q;
	end
	assign dq_s = s2_q[DW-1:0];
	assign lclk_rise = (st_q == H_BURST)
		& (div_q == TMR_W'(CLK_HALF_CYC - 1)) & ~lclk_q;
	assign take = lclk_rise & avd_done_q & s2_q[16];

	always_comb
	begin
		st_d = st_q;
		tmr_d = (tmr_q == '0) ? tmr_q : tmr_q - 1'b1;
		unique case (st_q)
			H_IDLE:
				if (go)
				begin
					st_d = (w_q[1:0] == OP_BURST) ? H_BURST : H_ADDR;
					tmr_d = TMR_W'(STROBE_CYC);
				end
			H_ADDR:
				if (tmr_q == '0)
				begin
					st_d = (op_q == OP_WRITE) ? H_WRITE : H_RWAIT;
					tmr_d = (op_q == OP_WRITE) ? TMR_W'(STROBE_CYC)
						: TMR_W'(ACCESS_CYC);
				end
			H_RWAIT, H_WRITE, H_HOLD:
				if (tmr_q == '0)
				begin
					st_d = (st_q == H_WRITE) ? H_HOLD : H_GAP;
					tmr_d = TMR_W'(STROBE_CYC);
				end
			H_GAP:
				if (tmr_q == '0)
					st_d = H_IDLE;
			H_BURST:
				if (take && wcnt_q == len_q)
				begin
					st_d = H_GAP;
					tmr_d = TMR_W'(STROBE_CYC);
				end
		endcase
	end

	// Burst clock divider, strobe release flag and word counter
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST || st_q != H_BURST)
		begin
			div_q <= '0;
			lclk_q <= 1'b0;
			avd_done_q <= 1'b0;
			wcnt_q <= '0;
		end
		else
		begin
			div_q <= (div_q == TMR_W'(CLK_HALF_CYC - 1)) ? '0 : div_q + 1'b1;
			if (div_q == TMR_W'(CLK_HALF_CYC - 1))
				lclk_q <= ~lclk_q;
			// Strobe held through rise0, released at the following fall
			if (div_q == TMR_W'(CLK_HALF_CYC - 1) && lclk_q)
				avd_done_q <= 1'b1;
			if (take)
				wcnt_q <= wcnt_q + 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			st_q <= H_IDLE;
			tmr_q <= '0;
			rdata_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			if ((st_q == H_RWAIT && tmr_q == '0) || take)
				rdata_q <= dq_s;
		end
	end

	// Burst capture memory
	always_ff @(posedge CORE_CLK)
	begin
		if (take)
			cap_q[wcnt_q] <= dq_s;
	end

	// Pin levels from the one-hot state
	assign LINK.addr = addr_q;
	assign LINK.ce_n = (st_q == H_IDLE) | (st_q == H_GAP);
	assign LINK.avd_n = ~((st_q == H_ADDR)
		| ((st_q == H_BURST) & ~avd_done_q));
	assign LINK.oe_n = ~((st_q == H_RWAIT) | (st_q == H_BURST));
	assign LINK.we_n = ~(st_q == H_WRITE);
	assign LINK.host_dq_o = wdata_q;
	assign LINK.host_dq_oe = (st_q == H_WRITE) | (st_q == H_HOLD);
	assign LINK.lclk = lclk_q & (st_q == H_BURST);
	assign LINK.rst_n = hwrst_q;

endmodule

// >>> core/fbhp_pkg.sv
/*
 Shared constants for both ends of the flash buffer host port: widths,
 buffer map, device register words, host register offsets, timing and
 state encodings.
 Assumes a single core clock of 50 MHz on both ends.
*/
package fbhp_pkg;

	// ---------------------------------------------------------------
	// Link widths and pin sampling
	// ---------------------------------------------------------------
	localparam int AW = 16;
	localparam int DW = 16;
	localparam int P_RSTN = 0;
	localparam int P_LCLK = 1;
	localparam int P_OE = 2;
	localparam int P_WE = 3;
	localparam int P_AVD = 4;
	localparam int P_CE = 5;
	localparam int P_DQ = 6;
	localparam int P_ADDR = P_DQ + DW;
	localparam int SYNC_W = P_ADDR + AW;
	localparam logic [SYNC_W-1:0] PIN_IDLE = 38'h00_0000_003d;

	// ---------------------------------------------------------------
	// Buffer memory map, in words
	// ---------------------------------------------------------------
	localparam int BOOT_WORDS = 512;
	localparam int DATA_WORDS = 2048;
	localparam int MEM_WORDS = BOOT_WORDS + DATA_WORDS;
	localparam int MEM_IW = 12;
	localparam logic [AW-1:0] BOOT_END = 16'h0200;
	localparam logic [AW-1:0] MEM_END = 16'h0a00;
	localparam logic [AW-1:0] REG_CFG = 16'hf000;
	localparam logic [AW-1:0] REG_SECT = 16'hf001;
	localparam logic [AW-1:0] REG_CMD = 16'hf002;
	localparam logic [AW-1:0] REG_STAT = 16'hf003;

	// ---------------------------------------------------------------
	// Device register fields
	// ---------------------------------------------------------------
	localparam int LAT_W = 4;
	localparam int CFG_LAT_LSB = 0;
	localparam int BM_W = 3;
	localparam int CFG_BM_LSB = 4;
	localparam int CFG_SYNC_BIT = 7;
	localparam int CFG_IRQ_BIT = 8;
	localparam int CFG_WP_BIT = 9;
	localparam int STAT_RDY_BIT = 0;
	localparam int STAT_INT_BIT = 1;
	localparam int SECT_W = 3;
	localparam logic [DW-1:0] CFG_RESET = 16'h0004;
	localparam logic [SECT_W-1:0] SECT_RESET = 3'h1;
	localparam logic [SECT_W-1:0] SECT_MAX = 3'h4;
	localparam logic [LAT_W-1:0] MIN_LATENCY = 4'h4;
	localparam logic [LAT_W-1:0] LAT_LAST = 4'h1;
	localparam logic [BM_W-1:0] BM_4 = 3'h1;
	localparam logic [BM_W-1:0] BM_8 = 3'h2;
	localparam logic [BM_W-1:0] BM_16 = 3'h3;
	localparam logic [BM_W-1:0] BM_32 = 3'h4;
	localparam logic [AW-1:0] WRAP_4 = 16'h0003;
	localparam logic [AW-1:0] WRAP_8 = 16'h0007;
	localparam logic [AW-1:0] WRAP_16 = 16'h000f;
	localparam logic [AW-1:0] WRAP_32 = 16'h001f;
	localparam logic [AW-1:0] WRAP_CONT = 16'h03ff;

	// ---------------------------------------------------------------
	// Host registers on AXI4-Lite and host operations
	// ---------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] AX_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] AX_ADDR = 8'h04;
	localparam logic [AXI_AW-1:0] AX_WDATA = 8'h08;
	localparam logic [AXI_AW-1:0] AX_STAT = 8'h0c;
	localparam logic [AXI_AW-1:0] AX_RDATA = 8'h10;
	localparam logic [AXI_AW-1:0] AX_HWRST = 8'h14;
	localparam int AX_CAP_BIT = 7;
	localparam int CAP_W = 5;
	localparam int CAP_WORDS = 32;
	localparam int CTRL_LEN_LSB = 4;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_BURST = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CORE_CLK_NS = 20;
	localparam int LINK_CLK_NS = 160;
	localparam int STROBE_NS = 160;
	localparam int ACCESS_NS = 200;
	localparam int CLK_HALF_CYC = LINK_CLK_NS / (2 * CORE_CLK_NS);
	localparam int STROBE_CYC = (STROBE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int ACCESS_CYC = (ACCESS_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int TMR_W = 4;

	// ---------------------------------------------------------------
	// State encodings
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		B_IDLE = 3'b001,
		B_WAIT = 3'b010,
		B_DATA = 3'b100
	} fbhp_burst_t;

	typedef enum logic [6:0] {
		H_IDLE = 7'b0000001,
		H_ADDR = 7'b0000010,
		H_RWAIT = 7'b0000100,
		H_WRITE = 7'b0001000,
		H_HOLD = 7'b0010000,
		H_GAP = 7'b0100000,
		H_BURST = 7'b1000000
	} fbhp_host_t;

endpackage

// >>> core/fbhp_link_if.sv
/*
 Parallel link between host end and device end of the flash buffer
 host port, with one modport for each end.
 Assumes the bench joins both ends; the shared data wire and the
 interrupt wire are resolved here from the output enables.
*/
`timescale 1ns/100ps
interface fbhp_link_if;
	logic [15:0] addr;
	logic ce_n;
	logic avd_n;
	logic we_n;
	logic oe_n;
	logic lclk;
	logic rst_n;
	logic [15:0] host_dq_o;
	logic host_dq_oe;
	logic [15:0] dev_dq_o;
	logic dev_dq_oe;
	logic rdy;
	logic int_o;
	logic int_oe;
	logic [15:0] dq;
	logic int_line;

	// Wire levels; undriven lines read as pulled high
	assign dq = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : 16'hffff);
	assign int_line = int_oe ? int_o : 1'b1;

	modport host (
		output addr, ce_n, avd_n, we_n, oe_n, lclk, rst_n,
		output host_dq_o, host_dq_oe,
		input dq, rdy, int_line
	);
	modport dev (
		input addr, ce_n, avd_n, we_n, oe_n, lclk, rst_n, dq,
		output dev_dq_o, dev_dq_oe, rdy, int_o, int_oe
	);
endinterface

// >>> core/fbhp_device.sv
/*
 Device end of the flash buffer host port: buffer memory, four control
 words, asynchronous reads and writes, synchronous bursts.
 Assumes all link pins are asynchronous to CORE_CLK; the flash core
 behind it answers commands through CMD_START and CMD_DONE.
*/
`timescale 1ns/100ps
// Functional notes
// - Sixteen-bit data, one word per transfer
// - Burst clock up to 54 MHz; here the host divides CORE_CLK to a 160 ns (6.25 MHz) burst clock
// - Linear bursts of 4/8/16/32 words, wrapping
// - Continuous burst over a 1K-word span
// - Programmable latency, at least four clocks
// - Sector count setting, one to four
// - Address selects buffer memory or registers
// - Data bus driven only when reading
// - Interrupt pin reports command completion
// - Interrupt pin floats until drive enabled
// - Ready marks burst data, only while selected
// - Burst address latched on first strobed clock
// - Async address captured on strobe rising edge
// - Address inputs ignored while strobe high
// - Write data captured on write strobe rise
// - Reset pin ignored during boot load
// - Chip select high deselects and floats
// - 1 KB boot buffer plus 4 KB data
// - Status word polls ready or busy
// - Boot buffer write protection
// - Output buffers on only with output enable
module fbhp_device
	import fbhp_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SRST,
	fbhp_link_if.dev LINK,
	output logic CMD_START,
	output logic [DW-1:0] CMD_CODE,
	output logic [SECT_W-1:0] SECTOR_COUNT,
	input wire logic CMD_DONE,
	input wire logic BOOT_LOADING
);

	// -------------------------------------------------------------
	// Decoding helpers
	// -------------------------------------------------------------
	function automatic logic in_mem(input logic [AW-1:0] a);
		in_mem = a < MEM_END;
	endfunction

	function automatic logic in_boot(input logic [AW-1:0] a);
		in_boot = a < BOOT_END;
	endfunction

	// Wrap mask for the burst length code
	function automatic logic [AW-1:0] wrap_mask(input logic [BM_W-1:0] m);
		logic [AW-1:0] r;
		r = WRAP_CONT;
		if (m == BM_4)
			r = WRAP_4;
		else if (m == BM_8)
			r = WRAP_8;
		else if (m == BM_16)
			r = WRAP_16;
		else if (m == BM_32)
			r = WRAP_32;
		wrap_mask = r;
	endfunction

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_s1_q;
	logic [SYNC_W-1:0] pin_s2_q;
	logic [SYNC_W-1:0] pin_s3_q;
	logic [DW-1:0] mem_q [MEM_WORDS];
	logic [AW-1:0] addr_hold_q;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] baddr_q;
	logic [AW-1:0] baddr_d;
	logic [AW-1:0] rd_addr;
	logic [AW-1:0] addr_s;
	logic [AW-1:0] bmask;
	logic [DW-1:0] dq_s;
	logic [DW-1:0] dq_q;
	logic [DW-1:0] reg_word;
	logic [DW-1:0] rd_word;
	logic [DW-1:0] cfg_q;
	logic [DW-1:0] cmd_q;
	logic [SECT_W-1:0] sect_q;
	logic [SECT_W-1:0] sect_new;
	logic [LAT_W-1:0] lat_cfg;
	logic [LAT_W-1:0] lat_eff;
	logic [LAT_W-1:0] cnt_q;
	logic [LAT_W-1:0] cnt_d;
	fbhp_burst_t st_q;
	fbhp_burst_t st_d;
	logic ce_s;
	logic active;
	logic avd_s;
	logic avd_rise;
	logic we_rise;
	logic oe_s;
	logic clk_rise;
	logic hw_rst;
	logic burst_go;
	logic wr_ev;
	logic wr_mem;
	logic wr_cfg;
	logic wr_sect;
	logic wr_cmd;
	logic wr_stat;
	logic int_clr;
	logic busy_q;
	logic int_pend_q;
	logic start_q;

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	assign pin_raw = {LINK.addr, LINK.dq, LINK.ce_n, LINK.avd_n,
		LINK.we_n, LINK.oe_n, LINK.lclk, LINK.rst_n};

	// Two stages, third stage only for edge finding
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			pin_s1_q <= PIN_IDLE;
			pin_s2_q <= PIN_IDLE;
			pin_s3_q <= PIN_IDLE;
		end
		else
		begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Synchronised levels and edges
	assign addr_s = pin_s2_q[P_ADDR +: AW];
	assign dq_s = pin_s2_q[P_DQ +: DW];
	assign ce_s = pin_s2_q[P_CE];
	assign active = ~ce_s;
	assign avd_s = pin_s2_q[P_AVD];
	assign oe_s = pin_s2_q[P_OE];
	assign avd_rise = avd_s & ~pin_s3_q[P_AVD];
	assign we_rise = pin_s2_q[P_WE] & ~pin_s3_q[P_WE];
	assign clk_rise = pin_s2_q[P_LCLK] & ~pin_s3_q[P_LCLK];
	assign hw_rst = ~pin_s2_q[P_RSTN] & ~BOOT_LOADING;

	// -------------------------------------------------------------
	// Address capture
	// -------------------------------------------------------------
	// Address followed only while strobe low, taken at its rise
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			addr_hold_q <= '0;
			addr_q <= '0;
		end
		else
		begin
			if (!avd_s)
				addr_hold_q <= addr_s;
			if (avd_rise && active)
				addr_q <= addr_hold_q;
		end
	end

	// -------------------------------------------------------------
	// Write decode
	// -------------------------------------------------------------
	assign wr_ev = we_rise & active;
	assign wr_mem = wr_ev & in_mem(addr_q)
		& ~(in_boot(addr_q) & cfg_q[CFG_WP_BIT]);
	assign wr_cfg = wr_ev & (addr_q == REG_CFG);
	assign wr_sect = wr_ev & (addr_q == REG_SECT);
	assign wr_cmd = wr_ev & (addr_q == REG_CMD);
	assign wr_stat = wr_ev & (addr_q == REG_STAT);
	assign int_clr = wr_stat & dq_s[STAT_INT_BIT];

	// Sector count kept within one to four
	assign sect_new = (dq_s[SECT_W-1:0] == '0) ? SECT_RESET :
		(dq_s[SECT_W-1:0] > SECT_MAX) ? SECT_MAX :
		dq_s[SECT_W-1:0];

	// Buffer memory, boot part then data part
	always_ff @(posedge CORE_CLK)
	begin
		if (wr_mem)
			mem_q[addr_q[MEM_IW-1:0]] <= dq_s;
	end

	// Control words, busy and completion flag
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST || hw_rst)
		begin
			cfg_q <= CFG_RESET;
			sect_q <= SECT_RESET;
			cmd_q <= '0;
			busy_q <= 1'b0;
			int_pend_q <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= wr_cmd;
			if (wr_cfg)
				cfg_q <= dq_s;
			if (wr_sect)
				sect_q <= sect_new;
			if (wr_cmd)
				cmd_q <= dq_s;
			busy_q <= wr_cmd | (busy_q & ~CMD_DONE);
			int_pend_q <= (CMD_DONE & busy_q) | (int_pend_q & ~int_clr);
		end
	end

	// -------------------------------------------------------------
	// Burst sequencer
	// -------------------------------------------------------------
	assign lat_cfg = cfg_q[CFG_LAT_LSB +: LAT_W];
	assign lat_eff = (lat_cfg < MIN_LATENCY) ? MIN_LATENCY : lat_cfg;
	assign bmask = wrap_mask(cfg_q[CFG_BM_LSB +: BM_W]);
	assign burst_go = cfg_q[CFG_SYNC_BIT] & clk_rise & ~avd_s;

	// Latch start, count latency, then step with wrap
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		baddr_d = baddr_q;
		if (!active)
			st_d = B_IDLE;
		else
			unique case (st_q)
				B_IDLE:
					if (burst_go)
					begin
						st_d = B_WAIT;
						cnt_d = lat_eff - 1'b1;
						baddr_d = addr_s;
					end
				B_WAIT:
					if (clk_rise)
					begin
						if (cnt_q == LAT_LAST)
							st_d = B_DATA;
						cnt_d = cnt_q - 1'b1;
					end
				B_DATA:
					if (clk_rise)
						baddr_d = (baddr_q & ~bmask)
							| ((baddr_q + 1'b1) & bmask);
			endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (SRST || hw_rst)
		begin
			st_q <= B_IDLE;
			cnt_q <= '0;
			baddr_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			baddr_q <= baddr_d;
		end
	end

	// -------------------------------------------------------------
	// Read path
	// -------------------------------------------------------------
	assign rd_addr = (st_q == B_IDLE) ? addr_q : baddr_q;
	assign reg_word = (rd_addr == REG_CFG) ? cfg_q :
		(rd_addr == REG_SECT) ? {{(DW-SECT_W){1'b0}}, sect_q} :
		(rd_addr == REG_CMD) ? cmd_q :
		(rd_addr == REG_STAT) ?
		{{(DW-2){1'b0}}, int_pend_q, ~busy_q} : '0;
	assign rd_word = in_mem(rd_addr) ?
		mem_q[rd_addr[MEM_IW-1:0]] : reg_word;

	// Output word register
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
			dq_q <= '0;
		else
			dq_q <= rd_word;
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign LINK.dev_dq_o = dq_q;
	assign LINK.dev_dq_oe = active & ~oe_s;
	assign LINK.rdy = active & (st_q == B_DATA);
	assign LINK.int_o = int_pend_q;
	assign LINK.int_oe = cfg_q[CFG_IRQ_BIT];
	assign CMD_START = start_q;
	assign CMD_CODE = cmd_q;
	assign SECTOR_COUNT = sect_q;

endmodule

// >>> verif/fbhp_link_sva.sv
/*
 Link checker for the flash buffer host port.
 Assumes the bench wires it to the link signals beside the interface.
*/
`timescale 1ns/100ps
module fbhp_link_sva (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic ce_n,
	input wire logic avd_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic lclk,
	input wire logic host_dq_oe,
	input wire logic dev_dq_oe,
	input wire logic rdy,
	input wire logic int_oe
);
	logic lclk_q;
	logic [7:0] rises_q;

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	// Burst clock rises since select
	always_ff @(posedge CORE_CLK)
	begin
		lclk_q <= lclk;
		rises_q <= ce_n ? 8'h00 : rises_q + {7'h00, lclk & ~lclk_q};
	end

	// Read cycle and burst steps
	sequence s_rd_open;
		!ce_n && avd_n && $fell(oe_n);
	endsequence
	sequence s_rdy_on;
		rdy ##1 !ce_n;
	endsequence

	// Link properties; device sees pins two cycles late
	property p_rd_drive; s_rd_open |-> ##[1:8] dev_dq_oe; endproperty
	property p_rdy_sel; rdy |-> !$past(ce_n, 2); endproperty
	property p_rdy_hold; s_rdy_on |-> rdy; endproperty
	property p_float; dev_dq_oe |-> !$past(ce_n, 2); endproperty
	property p_oe_only; dev_dq_oe |-> !$past(oe_n, 2); endproperty
	property p_one_drv; host_dq_oe |-> !dev_dq_oe; endproperty
	property p_wr_data; !we_n |-> host_dq_oe; endproperty
	property p_lclk_idle; ce_n |-> !lclk; endproperty
	property p_avd_sel; !avd_n |-> !ce_n; endproperty
	property p_int_float; $fell(SRST) |-> !int_oe; endproperty
	property p_lat; $rose(rdy) |-> rises_q >= 8'h04; endproperty

	a_rd_drive: assert property (p_rd_drive) else $error("no drive");
	a_rdy_sel: assert property (p_rdy_sel) else $error("rdy idle");
	a_rdy_hold: assert property (p_rdy_hold) else $error("rdy drop");
	a_float: assert property (p_float) else $error("dq driven");
	a_oe_only: assert property (p_oe_only) else $error("dq no oe");
	a_one_drv: assert property (p_one_drv) else $error("dq clash");
	a_wr_data: assert property (p_wr_data) else $error("we no dq");
	a_lclk_idle: assert property (p_lclk_idle) else $error("lclk");
	a_avd_sel: assert property (p_avd_sel) else $error("avd");
	a_int_float: assert property (p_int_float) else $error("irq");
	a_lat: assert property (p_lat) else $error("latency");
endmodule

// >>> verif/tb_top.sv
/*
 Self-checking bench: host end and device end joined by the link,
 software side driven over AXI4-Lite.
 Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/100ps
module tb_top
	import fbhp_pkg::*;
;
	logic clk, srst, done, start, boot;
	logic awv, awr, wv, wr, bv, bry, arv, arr, rv, rry;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, v;
	logic [1:0] br, rr;
	logic [15:0] code;
	logic [2:0] sect;
	int miscompares, n_compared, starts;

	fbhp_link_if link ();
	fbhp_host fbhp_host_i (.CORE_CLK(clk), .SRST(srst), .LINK(link.host),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
	fbhp_device fbhp_device_i (.CORE_CLK(clk), .SRST(srst),
		.LINK(link.dev), .CMD_START(start), .CMD_CODE(code),
		.SECTOR_COUNT(sect), .CMD_DONE(done), .BOOT_LOADING(boot));
	fbhp_link_sva fbhp_link_sva_i (.CORE_CLK(clk), .SRST(srst),
		.ce_n(link.ce_n), .avd_n(link.avd_n), .we_n(link.we_n),
		.oe_n(link.oe_n), .lclk(link.lclk), .host_dq_oe(link.host_dq_oe),
		.dev_dq_oe(link.dev_dq_oe), .rdy(link.rdy), .int_oe(link.int_oe));

	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", what, exp, seen);
		end
	endtask

	task automatic hang();
		miscompares++;
		give_verdict();
	endtask

	// AXI write, both channels offered together
	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (bv)
			begin
				bry <= 1'b0;
				check("bresp", {30'h0, br}, {30'h0, er});
				return;
			end
		end
		hang();
	endtask

	// AXI read
	task automatic axr(logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
			begin
				rry <= 1'b0;
				d = rd;
				check("rresp", {30'h0, rr}, {30'h0, er});
				return;
			end
		end
		hang();
	endtask

	// One link operation, polled until idle
	task automatic dev_op(logic [31:0] ctrl, logic [15:0] a, d);
		logic [31:0] s;
		axw(AX_ADDR, {16'h0, a}, RESP_OKAY);
		axw(AX_WDATA, {16'h0, d}, RESP_OKAY);
		axw(AX_CTRL, ctrl, RESP_OKAY);
		for (int n = 0; n < 200; n++)
		begin
			axr(AX_STAT, s, RESP_OKAY);
			if (s[0] === 1'b0)
				return;
		end
		hang();
	endtask

	task automatic rd_chk(logic [15:0] a, exp);
		dev_op(32'h0, a, 16'h0);
		axr(AX_RDATA, v, RESP_OKAY);
		check("word", v, {16'h0, exp});
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Command pulses seen
	always @(posedge clk)
		if (start === 1'b1)
			starts++;

	initial
	begin
		{srst, awv, wv, bry, arv, rry, done, boot} = 8'h80;
		{awa, ara, wd} = '0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		axr(AX_STAT, v, RESP_OKAY);
		check("stat", v, 32'h2);
		check("int_oe", {31'h0, link.int_oe}, 32'h0);
		axr(8'h18, v, RESP_SLVERR);
		check("unmapped", v, 32'h0);
		$display("T1 done");
		dev_op(32'h1, 16'h0000, 16'ha5c3);
		dev_op(32'h1, 16'h09ff, 16'h5a3c);
		rd_chk(16'h0000, 16'ha5c3);
		rd_chk(16'h09ff, 16'h5a3c);
		rd_chk(16'h0a00, 16'h0000);
		rd_chk(REG_CFG, CFG_RESET);
		for (int i = 0; i < 8; i++)
		begin
			dev_op(32'h1, REG_SECT, 16'(i));
			check("sect", 32'(sect), i == 0 ? 1 : i > 4 ? 4 : i);
		end
		dev_op(32'h1, REG_CFG, 16'h0204);
		dev_op(32'h1, 16'h0000, 16'h1234);
		rd_chk(16'h0000, 16'ha5c3);
		$display("T2 done");
		for (int i = 0; i < 8; i++)
			dev_op(32'h1, 16'h0200 + 16'(i), 16'hc000 + 16'(i));
		for (int b = 0; b < 2; b++)
		begin
			dev_op(32'h1, REG_CFG, b ? 16'h0085 : 16'h0094);
			dev_op(32'h32, 16'h0202, 16'h0);
			for (int i = 0; i < 4; i++)
			begin
				axr(8'h80 + 8'(4 * i), v, RESP_OKAY);
				check("burst", v, 'hc000 + (b ? i + 2 : (i + 2) % 4));
			end
		end
		$display("T3 done");
		dev_op(32'h1, REG_CFG, 16'h0104);
		check("int_oe", {31'h0, link.int_oe}, 32'h1);
		dev_op(32'h1, REG_CMD, 16'h00e5);
		check("code", {16'h0, code}, 32'he5);
		check("starts", starts, 32'h1);
		rd_chk(REG_STAT, 16'h0000);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		rd_chk(REG_STAT, 16'h0003);
		dev_op(32'h1, REG_STAT, 16'h0002);
		check("int_line", {31'h0, link.int_line}, 32'h0);
		boot <= 1'b1;
		axw(AX_HWRST, 32'h0, RESP_OKAY);
		axw(AX_HWRST, 32'h1, RESP_OKAY);
		rd_chk(REG_CFG, 16'h0104);
		boot <= 1'b0;
		axw(AX_HWRST, 32'h0, RESP_OKAY);
		axw(AX_HWRST, 32'h1, RESP_OKAY);
		rd_chk(REG_CFG, CFG_RESET);
		check("int_oe", {31'h0, link.int_oe}, 32'h0);
		$display("T4 done");
		give_verdict();
	end
endmodule
